// *** verilog/isl_pkg.sv ***
// shared constants for the interrupt status low bits block
package isl_pkg;
  // register byte offsets
  localparam logic [7:0] ISL_STATUS_OFS = 8'h58;
  localparam logic [7:0] ISL_THRESH_OFS = 8'h60;
  localparam logic [7:0] ISL_LEVELS_OFS = 8'h64;
  localparam logic [7:0] ISL_DMA_OFS = 8'h68;
  localparam logic [7:0] ISL_TIMER_OFS = 8'h6c;
  // status bit positions
  localparam int ISL_B_RXDMA = 20;
  localparam int ISL_B_TIMER = 19;
  localparam int ISL_B_POWER = 17;
  localparam int ISL_B_TXSOVF = 16;
  localparam int ISL_B_LONG = 15;
  localparam int ISL_B_RXERR = 14;
  localparam int ISL_B_TXERR = 13;
  localparam int ISL_B_PIN = 12;
  localparam int ISL_B_TXDOVR = 10;
  localparam int ISL_B_TXAVAIL = 9;
  localparam int ISL_B_TXSFULL = 8;
  localparam int ISL_B_TXSLVL = 7;
  localparam int ISL_B_DROP = 6;
  localparam int ISL_B_RXSFULL = 4;
  localparam int ISL_B_RXSLVL = 3;
  // sticky write-one-to-clear bits
  localparam logic [31:0] ISL_W1C_MASK = 32'h001b_e7d8;
  localparam logic [31:0] ISL_STATUS_RST = 32'h0000_0000;
  // receive frame length limits in bytes
  localparam logic [15:0] ISL_FRAME_MAX = 16'h0800;
  // threshold register field positions
  localparam int ISL_TXAVAIL_LSB = 0;
  localparam int ISL_TXSLVL_LSB = 8;
  localparam int ISL_RXSLVL_LSB = 16;
  localparam logic [15:0] ISL_TIMER_ALL_ONES = 16'hffff;
endpackage : isl_pkg

// *** verilog/isl_top.sv ***
// interrupt status low bits with axi4-lite register access
// Function
// - rx dma count drained sets bit 20
// - timer wraps past zero sets bit 19
// - any power event sets bit 17
// - write one clears bit 17
// - no deassert interval for power event
// - tx status fifo overflow sets bit 16
// - frame of 2048 bytes sets bit 15
// - frames of 2049+ truncated to 2048
// - receive error sets bit 14
// - transmit error sets bit 13
// - bit 12 read-only pin event
// - write to full tx fifo sets 10
// - tx space above threshold sets 9
// - tx status fifo full sets 8
// - tx status level reached sets 7
// - dropped frame sets bit 6
// - rx status push when full sets 4
// - rx status level reached sets 3
// - write one clears, zero keeps
// - status records regardless of enables
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module isl_top
  import isl_pkg::*;
#(
  parameter int LEVEL_W = 8,
  parameter int SPACE_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_dma_word_read,
  input wire logic [2:0] rx_dma_word_bytes,
  input wire logic timer_tick,
  input wire logic power_event,
  input wire logic tx_status_push,
  input wire logic [LEVEL_W-1:0] tx_status_level,
  input wire logic tx_status_full,
  input wire logic rx_frame_byte,
  input wire logic rx_frame_end,
  input wire logic rx_error,
  input wire logic tx_error,
  input wire logic pin_event,
  input wire logic tx_data_write,
  input wire logic tx_data_full,
  input wire logic [SPACE_W-1:0] tx_data_space,
  input wire logic rx_frame_drop,
  input wire logic rx_status_push,
  input wire logic rx_status_full,
  input wire logic [LEVEL_W-1:0] rx_status_level,
  output logic rx_byte_store,
  output logic power_irq_raw,
  output logic status_any
);

  // level fields hold 8 bits, space field 16
  if (LEVEL_W < 1 || LEVEL_W > 8 || SPACE_W < 1 || SPACE_W > 16) begin : g_bad_width
    $error("isl_top: unsupported parameter widths");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_ok;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_ff[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] status;
    logic [SPACE_W-1:0] space_thr;
    logic [LEVEL_W-1:0] txs_thr;
    logic [LEVEL_W-1:0] rxs_thr;
    logic [15:0] dma_left;
    logic [15:0] timer;
    logic [15:0] frame_len;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic byte_store;
    logic power_raw;
    logic any;
  } isl_state_s;

  isl_state_s st_ff;
  isl_state_s nxt_st;

  // ----------------------------------------
  // register word helpers
  // ----------------------------------------

  function automatic logic [31:0] isl_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : isl_merge

  function automatic logic [31:0] isl_level_word(input logic [LEVEL_W-1:0] txs,
                                                 input logic [LEVEL_W-1:0] rxs);
    return {8'h0, 8'(rxs), 8'(txs), 8'h0};
  endfunction : isl_level_word

  function automatic logic [31:0] isl_space_word(input logic [SPACE_W-1:0] sp);
    return {16'h0, 16'(sp)};
  endfunction : isl_space_word

  function automatic logic isl_known(input logic [7:0] a);
    return (a == ISL_STATUS_OFS) || (a == ISL_THRESH_OFS) || (a == ISL_LEVELS_OFS) ||
           (a == ISL_DMA_OFS) || (a == ISL_TIMER_OFS);
  endfunction : isl_known

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] wmask;
    logic [31:0] lv;
    logic do_wr;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] wb;
    logic [15:0] dma_dec;
    set_v = 32'h0;
    clr_v = 32'h0;
    wmask = 32'h0;
    lv = 32'h0;
    dma_dec = 16'h0;
    do_wr = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    wa = st_ff.awaddr;
    wd = st_ff.wdata;
    wb = st_ff.wstrb;
    nxt_st = st_ff;
    nxt_st.byte_store = 1'b0;

    // ----------------------------------------
    // write channel capture, either order
    // ----------------------------------------
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.awaddr = s_axi_awaddr[7:0];
      nxt_st.aw_held = 1'b1;
      nxt_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
      nxt_st.w_held = 1'b1;
      nxt_st.wready = 1'b0;
    end
    if (do_wr) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = isl_known(wa) ? 2'b00 : 2'b10;
      if (wa == ISL_STATUS_OFS) begin
        wmask = isl_merge(32'h0, 32'hffff_ffff, wb);
        clr_v = wd & wmask & ISL_W1C_MASK;
      end else if (wa == ISL_THRESH_OFS) begin
        lv = isl_merge(isl_level_word(st_ff.txs_thr, st_ff.rxs_thr), wd, wb);
        nxt_st.txs_thr = lv[ISL_TXSLVL_LSB +: LEVEL_W];
        nxt_st.rxs_thr = lv[ISL_RXSLVL_LSB +: LEVEL_W];
      end else if (wa == ISL_LEVELS_OFS) begin
        lv = isl_merge(isl_space_word(st_ff.space_thr), wd, wb);
        nxt_st.space_thr = lv[ISL_TXAVAIL_LSB +: SPACE_W];
      end else if (wa == ISL_DMA_OFS) begin
        lv = isl_merge({16'h0, st_ff.dma_left}, wd, wb);
        nxt_st.dma_left = lv[15:0];
      end else if (wa == ISL_TIMER_OFS) begin
        lv = isl_merge({16'h0, st_ff.timer}, wd, wb);
        nxt_st.timer = lv[15:0];
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = 2'b00;
      if (s_axi_araddr[7:0] == ISL_STATUS_OFS) begin
        nxt_st.rdata = (st_ff.status & ISL_W1C_MASK) | (32'(pin_event) << ISL_B_PIN);
      end else if (s_axi_araddr[7:0] == ISL_THRESH_OFS) begin
        nxt_st.rdata = isl_level_word(st_ff.txs_thr, st_ff.rxs_thr);
      end else if (s_axi_araddr[7:0] == ISL_LEVELS_OFS) begin
        nxt_st.rdata = isl_space_word(st_ff.space_thr);
      end else if (s_axi_araddr[7:0] == ISL_DMA_OFS) begin
        nxt_st.rdata = {16'h0, st_ff.dma_left};
      end else if (s_axi_araddr[7:0] == ISL_TIMER_OFS) begin
        nxt_st.rdata = {16'h0, st_ff.timer};
      end else begin
        nxt_st.rdata = 32'h0;
        nxt_st.rresp = 2'b10;
      end
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    // dma count drained
    if (rx_dma_word_read && st_ff.dma_left != 16'h0) begin
      dma_dec = (st_ff.dma_left > 16'(rx_dma_word_bytes)) ?
                16'(st_ff.dma_left - 16'(rx_dma_word_bytes)) : 16'h0;
      nxt_st.dma_left = dma_dec;
      if (dma_dec == 16'h0) begin
        set_v[ISL_B_RXDMA] = 1'b1;
      end
    end
    if (timer_tick) begin
      nxt_st.timer = 16'(st_ff.timer - 16'h1);
      if (st_ff.timer == 16'h0) begin
        set_v[ISL_B_TIMER] = 1'b1;
      end
    end
    if (power_event) begin
      set_v[ISL_B_POWER] = 1'b1;
    end
    if (tx_status_push && tx_status_full) begin
      set_v[ISL_B_TXSOVF] = 1'b1;
    end
    if (rx_frame_byte) begin
      if (st_ff.frame_len < ISL_FRAME_MAX) begin
        nxt_st.frame_len = 16'(st_ff.frame_len + 16'h1);
        nxt_st.byte_store = 1'b1;
      end
      if (st_ff.frame_len == 16'(ISL_FRAME_MAX - 16'h1)) begin
        set_v[ISL_B_LONG] = 1'b1;
      end
    end
    if (rx_frame_end) begin
      nxt_st.frame_len = 16'h0;
    end
    if (rx_error) begin
      set_v[ISL_B_RXERR] = 1'b1;
    end
    if (tx_error) begin
      set_v[ISL_B_TXERR] = 1'b1;
    end
    if (tx_data_write && tx_data_full) begin
      set_v[ISL_B_TXDOVR] = 1'b1;
    end
    if (tx_data_space > st_ff.space_thr) begin
      set_v[ISL_B_TXAVAIL] = 1'b1;
    end
    if (tx_status_full) begin
      set_v[ISL_B_TXSFULL] = 1'b1;
    end
    if (tx_status_level >= st_ff.txs_thr) begin
      set_v[ISL_B_TXSLVL] = 1'b1;
    end
    if (rx_frame_drop) begin
      set_v[ISL_B_DROP] = 1'b1;
    end
    if (rx_status_push && rx_status_full) begin
      set_v[ISL_B_RXSFULL] = 1'b1;
    end
    if (rx_status_level >= st_ff.rxs_thr) begin
      set_v[ISL_B_RXSLVL] = 1'b1;
    end

    // ----------------------------------------
    // status update
    // ----------------------------------------
    // sticky, set beats clear
    nxt_st.status = ((st_ff.status & ~clr_v) | set_v) & ISL_W1C_MASK;
    nxt_st.power_raw = nxt_st.status[ISL_B_POWER];
    nxt_st.any = (nxt_st.status != 32'h0) || pin_event;
  end

  always_ff @(posedge sys_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      st_ff <= '0;
      st_ff.status <= ISL_STATUS_RST;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.space_thr <= '1;
      st_ff.txs_thr <= '1;
      st_ff.rxs_thr <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign rx_byte_store = st_ff.byte_store;
  assign power_irq_raw = st_ff.power_raw;
  assign status_any = st_ff.any;

endmodule : isl_top

// *** tb/isl_top_asserts.sv ***
// assertion checker for the interrupt status low bits
`timescale 1ns/10ps
module isl_top_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic power_event,
  input wire logic rx_error,
  input wire logic tx_error,
  input wire logic pin_event,
  input wire logic rx_frame_byte,
  input wire logic rx_byte_store,
  input wire logic power_irq_raw,
  input wire logic status_any
);
  logic [1:0] live_ff;
  // design leaves reset two edges after the pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_ff <= 2'h0;
    end else begin
      live_ff <= {live_ff[0], 1'b1};
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!live_ff[1]);
  AST_PWR_SET: assert property (power_event |=> power_irq_raw)
    else $error("power event did not raise the power flag");
  AST_PWR_ANY: assert property (power_irq_raw |-> status_any)
    else $error("power flag set but summary low");
  AST_PIN_ANY: assert property (pin_event |=> status_any)
    else $error("pin event not in summary");
  AST_RXE_ANY: assert property (rx_error |=> status_any)
    else $error("receive error not recorded");
  AST_TXE_ANY: assert property (tx_error |=> status_any)
    else $error("transmit error not recorded");
  AST_PWR_HOLD: assert property (power_irq_raw && s_axi_wready && !s_axi_wvalid
    |=> power_irq_raw)
    else $error("power flag dropped without a write");
  AST_STORE_SRC: assert property (rx_byte_store |-> $past(rx_frame_byte))
    else $error("byte stored without a received byte");
  AST_B_AFTER_W: assert property ($rose(s_axi_bvalid) |-> !s_axi_wready)
    else $error("write response without a taken write");
  AST_PWR_FALL: assert property ($fell(power_irq_raw) |-> $rose(s_axi_bvalid))
    else $error("power flag dropped apart from its clearing write");
endmodule : isl_top_asserts
bind isl_top isl_top_asserts isl_top_asserts_i (.sys_clk, .rst_n, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .power_event, .rx_error, .tx_error, .pin_event,
  .rx_frame_byte, .rx_byte_store, .power_irq_raw, .status_any);

// *** tb/isl_top_tb.sv ***
// self-checking bench for the interrupt status low bits
`timescale 1ns/10ps
module isl_top_tb;
  import isl_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [31:0] aa = '0, wd = '0, ra = '0, rdat, stored = '0;
  logic av = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic awr, wr, bv, arr, rvl, store, pirq, any;
  logic [1:0] bresp, rresp;
  logic [10:0] ev = '0;
  logic dw = 1'h0, fb = 1'h0, fe = 1'h0, tt = 1'h0;
  logic [2:0] db = 3'h4;
  logic [7:0] tl = '0, rl = '0;
  logic [11:0] sp = '0;
  logic [3:0] ws = 4'hf;
  int n_errors = 0, comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (store === 1'h1) stored = stored + 32'h1;
  isl_top isl_top_i (.sys_clk, .rst_n, .s_axi_awaddr(aa), .s_axi_awvalid(av),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr), .rx_dma_word_read(dw),
    .rx_dma_word_bytes(db), .timer_tick(tt), .power_event(ev[3]), .tx_status_push(ev[4]),
    .tx_status_level(tl), .tx_status_full(ev[5]), .rx_frame_byte(fb), .rx_frame_end(fe),
    .rx_error(ev[0]), .tx_error(ev[1]), .pin_event(ev[10]), .tx_data_write(ev[6]),
    .tx_data_full(ev[7]), .tx_data_space(sp), .rx_frame_drop(ev[2]),
    .rx_status_push(ev[8]), .rx_status_full(ev[9]), .rx_status_level(rl),
    .rx_byte_store(store), .power_irq_raw(pirq), .status_any(any));
  task automatic test_done;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic limit(input int n);
    if (n >= 40) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, n, 40);
      test_done();
    end
  endtask : limit
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    n = 0;
    aa <= {24'h0, a};
    wd <= d;
    av <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (av && awr) av <= 1'h0;
      if (wv && wr) wv <= 1'h0;
    end while (bv !== 1'h1 && n < 40);
    br <= 1'h0;
    limit(n);
    chk({30'h0, bresp}, {30'h0, r});
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    n = 0;
    ra <= {24'h0, a};
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arv && arr) arv <= 1'h0;
    end while (rvl !== 1'h1 && n < 40);
    rr <= 1'h0;
    limit(n);
    chk(rdat, e);
    chk({30'h0, rresp}, {30'h0, r});
  endtask : rd_reg
  function automatic logic [31:0] exp_of(input logic [10:0] e);
    logic [31:0] s;
    s = '0;
    s[ISL_B_RXERR] = e[0];
    s[ISL_B_TXERR] = e[1];
    s[ISL_B_DROP] = e[2];
    s[ISL_B_POWER] = e[3];
    s[ISL_B_TXSOVF] = e[4] & e[5];
    s[ISL_B_TXSFULL] = e[5];
    s[ISL_B_TXDOVR] = e[6] & e[7];
    s[ISL_B_RXSFULL] = e[8] & e[9];
    return s;
  endfunction : exp_of
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask
  initial begin
    logic [10:0] e;
    logic [31:0] m, x;
    logic [3:0] s;
    void'($urandom(20599));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rd_reg(ISL_STATUS_OFS, 32'h0, 2'h0);
    rd_reg(8'h70, 32'h0, 2'h2);
    for (int i = 0; i < 24; i++) begin
      e = (i < 10) ? 11'h1 << i : 11'($urandom) & 11'h3ff;
      @(posedge sys_clk);
      ev <= e;
      @(posedge sys_clk);
      ev <= '0;
      x = exp_of(e);
      rd_reg(ISL_STATUS_OFS, x, 2'h0);
      chk({31'h0, pirq}, {31'h0, x[ISL_B_POWER]});
      chk({31'h0, any}, {31'h0, |x});
      m = $urandom;
      s = (i < 10) ? 4'hf : 4'($urandom);
      ws <= s;
      wr_reg(ISL_STATUS_OFS, m, 2'h0);
      ws <= 4'hf;
      rd_reg(ISL_STATUS_OFS, x & ~(m & strb_mask(s)), 2'h0);
      wr_reg(ISL_STATUS_OFS, 32'hffff_ffff, 2'h0);
      chk({31'h0, pirq}, 32'h0);
      chk({31'h0, any}, 32'h0);
    end
    ev <= 11'h400;
    wr_reg(ISL_STATUS_OFS, 32'h0000_1000, 2'h0);
    rd_reg(ISL_STATUS_OFS, 32'h0000_1000, 2'h0);
    chk({31'h0, any}, 32'h1);
    ev <= '0;
    rd_reg(ISL_STATUS_OFS, 32'h0, 2'h0);
    tl <= 8'h03;
    rl <= 8'h03;
    sp <= 12'h004;
    wr_reg(ISL_THRESH_OFS, 32'h0004_0400, 2'h0);
    wr_reg(ISL_LEVELS_OFS, 32'h0000_0004, 2'h0);
    rd_reg(ISL_STATUS_OFS, 32'h0, 2'h0);
    tl <= 8'h04;
    rl <= 8'h04;
    sp <= 12'h005;
    rd_reg(ISL_STATUS_OFS, 32'h0000_0288, 2'h0);
    tl <= '0;
    rl <= '0;
    sp <= '0;
    rd_reg(ISL_STATUS_OFS, 32'h0000_0288, 2'h0);
    wr_reg(ISL_STATUS_OFS, 32'hffff_ffff, 2'h0);
    wr_reg(ISL_DMA_OFS, 32'h0000_0008, 2'h0);
    wr_reg(ISL_TIMER_OFS, 32'h0000_0001, 2'h0);
    for (int k = 0; k < 2; k++) begin
      dw <= 1'h1;
      tt <= 1'h1;
      @(posedge sys_clk);
      dw <= 1'h0;
      tt <= 1'h0;
      rd_reg(ISL_STATUS_OFS, k ? 32'h0018_0000 : 32'h0, 2'h0);
    end
    rd_reg(ISL_TIMER_OFS, 32'h0000_ffff, 2'h0);
    wr_reg(ISL_STATUS_OFS, 32'hffff_ffff, 2'h0);
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk);
      x = stored;
      @(posedge sys_clk);
      fb <= 1'h1;
      repeat (k ? 2050 : 2047) @(posedge sys_clk);
      fb <= 1'h0;
      fe <= 1'h1;
      @(posedge sys_clk);
      fe <= 1'h0;
      rd_reg(ISL_STATUS_OFS, k ? 32'h0000_8000 : 32'h0, 2'h0);
      chk(stored - x, k ? 32'h800 : 32'h7ff);
    end
    test_done();
  end
endmodule : isl_top_tb
